// ### rtl/sgram_burst_pkg.sv
// Constants, register map and state types for the burst data path.
package sgram_burst_pkg;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int COL_W = 6;
    localparam int MEM_DEPTH = 64;
    localparam int BANK_W = 3;
    localparam int ADDR_W = 9;
    localparam int CNT_W = 8;
    // Address bit that carries the auto precharge choice.
    localparam int AUTO_PRECHARGE_SELECT = 8;
    // Column bits taken in each of the two command cycles.
    localparam int COL_HALF = 3;
    // A lane is inverted when more than this many bits are ones.
    localparam logic [3:0] DBI_LIMIT = 4'h4;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_ACT = 3'h1,
        CMD_READ = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_PRE = 3'h4
    } cmd_t;

    typedef enum logic [2:0] {
        RD_IDLE = 3'h0,
        RD_PRE_HI = 3'h1,
        RD_PRE_LO = 3'h2,
        RD_DATA = 3'h3,
        RD_POST = 3'h4
    } rd_state_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_WAIT = 2'h1,
        WR_CAPT = 2'h2
    } wr_state_t;

    // Register byte offsets.
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_TIMING = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    // Configuration fields.
    localparam int CFG_CL_LSB = 0;
    localparam int CFG_WL_LSB = 4;
    localparam int CFG_BL_BIT = 8;
    localparam int CFG_RDBI_BIT = 9;
    localparam int CFG_WDBI_BIT = 10;
    localparam int TIM_MIN_ROW_ACTIVE_TIME_LSB = 0;
    localparam int TIM_TWR_LSB = 8;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0135;
    localparam logic [31:0] TIMING_RESET = 32'h0000_0410;

    // Status bits.
    localparam int ST_RD_ERR = 0;
    localparam int ST_WR_ERR = 1;
    localparam int ST_RD_BUSY = 2;
    localparam int ST_WR_BUSY = 3;
    localparam int ST_PCH_PEND = 4;

    localparam logic [CNT_W-1:0] READ_SPACING = 8'h04;
    localparam logic [CNT_W-1:0] BL_SHORT = 8'h04;
    localparam logic [CNT_W-1:0] BL_LONG = 8'h08;
    localparam logic [CNT_W-1:0] PRE_START = 8'h02;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
endpackage

// ### rtl/sgram_burst_data_path.sv
// Read and write burst data path of a graphics SDRAM, with register slave.
`timescale 1ns/10ps
`default_nettype none
module sgram_burst_data_path (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire sgram_burst_pkg::cmd_t cmd_code,
    input wire logic [sgram_burst_pkg::BANK_W-1:0] cmd_bank,
    input wire logic [sgram_burst_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [sgram_burst_pkg::DATA_W-1:0] dq_i,
    output logic [sgram_burst_pkg::DATA_W-1:0] dq_o,
    output logic dq_oe,
    input wire logic [sgram_burst_pkg::LANES-1:0] read_strobe_i,
    output logic [sgram_burst_pkg::LANES-1:0] read_strobe_o,
    output logic read_strobe_oe,
    input wire logic write_strobe_i,
    output logic [sgram_burst_pkg::LANES-1:0] inversion_flag_pin_o,
    output logic inversion_flag_pin_oe,
    output logic dq_odt_on,
    output logic precharge_pulse,
    output logic [sgram_burst_pkg::BANK_W-1:0] precharge_bank
);
    import sgram_burst_pkg::*;

    localparam int SYNC_W = DATA_W + LANES + 1;

    // Data-bus inversion of one word; returns flags above the word.
    function automatic logic [DATA_W+LANES-1:0] dbi_word(
        input logic [DATA_W-1:0] w, input logic en);
        logic [DATA_W-1:0] o;
        logic [LANES-1:0] f;
        logic [3:0] ones;
        o = w;
        f = '0;
        for (int l = 0; l < LANES; l++) begin
            ones = '0;
            for (int b = 0; b < LANE_W; b++) begin
                ones = ones + {3'h0, w[l*LANE_W+b]};
            end
            f[l] = en && (ones > DBI_LIMIT);
            if (f[l]) begin
                o[l*LANE_W +: LANE_W] = ~w[l*LANE_W +: LANE_W];
            end
        end
        return {f, o};
    endfunction

    // Column of element idx within a burst, wrapping in the array.
    function automatic logic [COL_W-1:0] col_at(
        input logic [COL_W-1:0] base, input logic [CNT_W-1:0] idx);
        return base + idx[COL_W-1:0];
    endfunction

    // Byte-enable merge for register writes.
    function automatic logic [31:0] be_merge(
        input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic [31:0] config_q, timing_q;
    logic [4:0] status_q;
    logic [31:0] avs_readdata_q;
    logic wait_q;
    rd_state_t rd_state_q, rd_state_d;
    wr_state_t wr_state_q;
    logic rd_cmd_d1_q, wr_cmd_d1_q, ap_d1_q;
    logic [COL_HALF-1:0] col_lo_q;
    logic [BANK_W-1:0] bank_d1_q, rd_bank_q, wr_bank_q, pch_bank_q;
    logic rd_pend_q, rd_pend_ap_q, rd_ap_q;
    logic [BANK_W-1:0] rd_pend_bank_q;
    logic [COL_W-1:0] rd_pend_col_q, rd_col_q;
    logic [CNT_W-1:0] rd_pend_cnt_q, rd_idx_q, rd_idx_d;
    logic [CNT_W-1:0] odt_cnt_q, row_cnt_q, wrec_cnt_q;
    logic [CNT_W-1:0] rd_gap_q, wr_gap_q, wr_wait_q, wr_idx_q;
    logic [COL_W-1:0] wr_col_q, wr_next_col_q;
    logic wr_ap_q, wr_next_q, wr_next_ap_q;
    logic [BANK_W-1:0] wr_next_bank_q;
    logic pch_pend_q;
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q;
    logic ws_level_q;
    logic [DATA_W-1:0] dq_q;
    logic [LANES-1:0] rs_q, flag_q;
    logic dq_oe_q, rs_oe_q, flag_oe_q, odt_q, pch_pulse_q;

    // Configuration decode.
    wire [CNT_W-1:0] cl = {4'h0, config_q[CFG_CL_LSB +: 4]};
    wire [CNT_W-1:0] wl = {4'h0, config_q[CFG_WL_LSB +: 4]};
    wire [CNT_W-1:0] bl = config_q[CFG_BL_BIT] ? BL_LONG : BL_SHORT;
    wire [CNT_W-1:0] bl_half = {1'b0, bl[CNT_W-1:1]};
    wire rd_dbi_en = config_q[CFG_RDBI_BIT];
    wire wr_dbi_en = config_q[CFG_WDBI_BIT];
    wire [CNT_W-1:0] min_row_active_time = timing_q[TIM_MIN_ROW_ACTIVE_TIME_LSB +: CNT_W];
    wire [CNT_W-1:0] write_recovery_time = timing_q[TIM_TWR_LSB +: CNT_W];

    // Bus decode; the request is served once, when waitrequest is low.
    wire req = avs_read || avs_write;
    wire acc = req && !wait_q;
    wire wr_cfg = acc && avs_write && avs_address == REG_CONFIG;
    wire wr_tim = acc && avs_write && avs_address == REG_TIMING;
    wire wr_st = acc && avs_write && avs_address == REG_STATUS;
    wire [31:0] st_word = {27'h0, status_q};
    wire [31:0] rd_word = avs_address == REG_CONFIG ? config_q :
                          avs_address == REG_TIMING ? timing_q :
                          avs_address == REG_STATUS ? st_word : 32'h0;

    // Command decode; the column's upper half arrives a cycle later.
    wire is_rd = cmd_code == CMD_READ;
    wire is_wr = cmd_code == CMD_WRITE;
    wire [COL_W-1:0] full_col = {cmd_addr[COL_HALF-1:0], col_lo_q};
    wire rd_err_set = is_rd && (rd_gap_q < READ_SPACING || rd_pend_q);
    wire wr_err_set = is_wr && (wr_gap_q < bl_half || wr_next_q);

    // Read sequencing.
    wire rd_pend_ready = rd_pend_q && rd_pend_cnt_q <= PRE_START;
    wire rd_last = rd_idx_q == bl - 8'h01;
    wire rd_start = (rd_state_q == RD_PRE_LO) ||
                    (rd_state_q == RD_DATA && rd_last && rd_pend_ready);
    wire [COL_W-1:0] rd_addr_d = rd_start ? rd_pend_col_q :
                                 col_at(rd_col_q, rd_idx_d);
    wire [DATA_W+LANES-1:0] rd_out = dbi_word(mem[rd_addr_d], rd_dbi_en);
    wire rd_done = rd_state_q == RD_DATA && rd_last && !rd_pend_ready;

    // Write strobe, data and inversion flags cross in from the link.
    wire [SYNC_W-1:0] s_in = {read_strobe_i, dq_i, write_strobe_i};
    wire ws_stable = s2_q[0] == s3_q[0];
    wire ws_edge = ws_stable && s3_q[0] != ws_level_q;
    wire ws_take = wr_state_q == WR_CAPT && ws_edge &&
                   (wr_idx_q != 8'h00 || s3_q[0]);
    wire [LANES-1:0] w_inv = s3_q[SYNC_W-1 -: LANES] & {LANES{wr_dbi_en}};
    wire [DATA_W-1:0] w_mask = {{LANE_W{w_inv[3]}}, {LANE_W{w_inv[2]}},
                                {LANE_W{w_inv[1]}}, {LANE_W{w_inv[0]}}};
    wire [DATA_W-1:0] w_data = s3_q[DATA_W:1] ^ w_mask;
    wire wr_last = ws_take && wr_idx_q == bl - 8'h01;
    wire pch_go = pch_pend_q && row_cnt_q >= min_row_active_time && wrec_cnt_q == 8'h00 &&
                  wr_state_q == WR_IDLE && rd_state_q != RD_DATA;

    // Next read state; a running burst is never cut short.
    always_comb begin
        rd_state_d = rd_state_q;
        rd_idx_d = rd_idx_q + 8'h01;
        case (rd_state_q)
            RD_IDLE, RD_POST: begin
                rd_state_d = rd_pend_ready ? RD_PRE_HI : RD_IDLE;
            end
            RD_PRE_HI: rd_state_d = RD_PRE_LO;
            RD_PRE_LO: rd_state_d = RD_DATA;
            RD_DATA: begin
                if (rd_last && !rd_pend_ready) begin
                    rd_state_d = RD_POST;
                end
            end
            default: rd_state_d = RD_IDLE;
        endcase
        if (rd_start) begin
            rd_idx_d = 8'h00;
        end
    end

    // Register slave: one wait cycle, then the answer.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wait_q <= 1'b1;
            avs_readdata_q <= 32'h0;
            config_q <= CONFIG_RESET;
            timing_q <= TIMING_RESET;
        end else begin
            wait_q <= !(req && wait_q);
            if (req && wait_q) begin
                avs_readdata_q <= rd_word;
            end
            if (wr_cfg) begin
                config_q <= be_merge(config_q, avs_writedata, avs_byteenable);
            end
            if (wr_tim) begin
                timing_q <= be_merge(timing_q, avs_writedata, avs_byteenable);
            end
        end
    end

    // Sticky errors clear on a written one; a new error wins the cycle.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= 5'h00;
        end else begin
            status_q[ST_RD_ERR] <= rd_err_set || (status_q[ST_RD_ERR] &&
                !(wr_st && avs_byteenable[0] && avs_writedata[ST_RD_ERR]));
            status_q[ST_WR_ERR] <= wr_err_set || (status_q[ST_WR_ERR] &&
                !(wr_st && avs_byteenable[0] && avs_writedata[ST_WR_ERR]));
            status_q[ST_RD_BUSY] <= rd_state_q != RD_IDLE || rd_pend_q;
            status_q[ST_WR_BUSY] <= wr_state_q != WR_IDLE;
            status_q[ST_PCH_PEND] <= pch_pend_q;
        end
    end

    // Command capture, spacing counters and the pending read slot.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_cmd_d1_q <= 1'b0;
            wr_cmd_d1_q <= 1'b0;
            ap_d1_q <= 1'b0;
            col_lo_q <= '0;
            bank_d1_q <= '0;
            rd_gap_q <= CNT_MAX;
            wr_gap_q <= CNT_MAX;
            rd_pend_q <= 1'b0;
            rd_pend_ap_q <= 1'b0;
            rd_pend_col_q <= '0;
            rd_pend_bank_q <= '0;
            rd_pend_cnt_q <= '0;
        end else begin
            rd_cmd_d1_q <= is_rd && !rd_err_set;
            wr_cmd_d1_q <= is_wr && !wr_err_set;
            ap_d1_q <= cmd_addr[AUTO_PRECHARGE_SELECT];
            col_lo_q <= cmd_addr[COL_HALF-1:0];
            bank_d1_q <= cmd_bank;
            rd_gap_q <= is_rd ? 8'h01 : rd_gap_q + {7'h0, rd_gap_q != CNT_MAX};
            wr_gap_q <= is_wr ? 8'h01 : wr_gap_q + {7'h0, wr_gap_q != CNT_MAX};
            if (rd_cmd_d1_q) begin
                rd_pend_q <= 1'b1;
                rd_pend_ap_q <= ap_d1_q;
                rd_pend_col_q <= full_col;
                rd_pend_bank_q <= bank_d1_q;
                rd_pend_cnt_q <= cl - 8'h02;
            end else begin
                if (rd_start) begin
                    rd_pend_q <= 1'b0;
                end
                if (rd_pend_cnt_q != 8'h00) begin
                    rd_pend_cnt_q <= rd_pend_cnt_q - 8'h01;
                end
            end
        end
    end

    // Read burst engine and its pins, all driven from flops.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_state_q <= RD_IDLE;
            rd_idx_q <= '0;
            rd_col_q <= '0;
            rd_ap_q <= 1'b0;
            rd_bank_q <= '0;
            dq_q <= '0;
            dq_oe_q <= 1'b0;
            rs_q <= '0;
            rs_oe_q <= 1'b0;
            flag_q <= '0;
            flag_oe_q <= 1'b0;
        end else begin
            rd_state_q <= rd_state_d;
            rd_idx_q <= rd_idx_d;
            if (rd_start) begin
                rd_col_q <= rd_pend_col_q;
                rd_ap_q <= rd_pend_ap_q;
                rd_bank_q <= rd_pend_bank_q;
            end
            // Strobe high on even elements gives one rising edge per pair.
            rs_q <= {LANES{rd_state_d == RD_PRE_HI || rd_state_d == RD_POST ||
                  (rd_state_d == RD_DATA && !rd_idx_d[0])}};
            rs_oe_q <= rd_state_d != RD_IDLE;
            dq_oe_q <= rd_state_d == RD_DATA;
            flag_oe_q <= rd_state_d == RD_DATA && rd_dbi_en;
            dq_q <= rd_out[DATA_W-1:0];
            flag_q <= rd_out[DATA_W +: LANES];
        end
    end

    // Termination is off for half the burst length from first data.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            odt_cnt_q <= '0;
            odt_q <= 1'b1;
        end else begin
            if (rd_start) begin
                odt_cnt_q <= bl_half;
            end else if (odt_cnt_q != 8'h00) begin
                odt_cnt_q <= odt_cnt_q - 8'h01;
            end
            odt_q <= !(rd_start || odt_cnt_q > 8'h01);
        end
    end

    // Link sampling: three stages, an edge counts once stages two and
    // three agree, so a strobe glitch shorter than a cycle is dropped.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            ws_level_q <= 1'b0;
        end else begin
            s1_q <= s_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (ws_stable) begin
                ws_level_q <= s3_q[0];
            end
        end
    end

    // Write burst engine; a WRITE queued before the current one's last capture waits behind it.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_state_q <= WR_IDLE;
            wr_wait_q <= '0;
            wr_idx_q <= '0;
            wr_col_q <= '0;
            wr_ap_q <= 1'b0;
            wr_bank_q <= '0;
            wr_next_q <= 1'b0;
            wr_next_ap_q <= 1'b0;
            wr_next_col_q <= '0;
            wr_next_bank_q <= '0;
        end else begin
            if (wr_cmd_d1_q && wr_state_q != WR_IDLE) begin
                wr_next_q <= 1'b1;
                wr_next_ap_q <= ap_d1_q;
                wr_next_col_q <= full_col;
                wr_next_bank_q <= bank_d1_q;
            end
            case (wr_state_q)
                WR_IDLE: begin
                    if (wr_cmd_d1_q) begin
                        wr_state_q <= WR_WAIT;
                        wr_wait_q <= wl;
                        wr_col_q <= full_col;
                        wr_ap_q <= ap_d1_q;
                        wr_bank_q <= bank_d1_q;
                    end
                end
                WR_WAIT: begin
                    wr_idx_q <= 8'h00;
                    wr_wait_q <= wr_wait_q - 8'h01;
                    if (wr_wait_q <= 8'h01) begin
                        wr_state_q <= WR_CAPT;
                    end
                end
                WR_CAPT: begin
                    if (ws_take) begin
                        wr_idx_q <= wr_idx_q + 8'h01;
                    end
                    if (wr_last && wr_next_q) begin
                        wr_idx_q <= 8'h00;
                        wr_next_q <= 1'b0;
                        wr_col_q <= wr_next_col_q;
                        wr_ap_q <= wr_next_ap_q;
                        wr_bank_q <= wr_next_bank_q;
                    end else if (wr_last) begin
                        wr_state_q <= WR_IDLE;
                    end
                end
                default: wr_state_q <= WR_IDLE;
            endcase
        end
    end

    // Write array port; data outside a capture window is ignored.
    always_ff @(posedge core_clk) begin
        if (ws_take) begin
            mem[col_at(wr_col_q, wr_idx_q)] <= w_data;
        end
    end

    // Row timing and precharge; explicit or auto, never mid-burst.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            row_cnt_q <= '0;
            wrec_cnt_q <= '0;
            pch_pend_q <= 1'b0;
            pch_bank_q <= '0;
            pch_pulse_q <= 1'b0;
        end else begin
            if (cmd_code == CMD_ACT) begin
                row_cnt_q <= 8'h00;
            end else if (row_cnt_q != CNT_MAX) begin
                row_cnt_q <= row_cnt_q + 8'h01;
            end
            if (wr_last) begin
                wrec_cnt_q <= write_recovery_time;
            end else if (wrec_cnt_q != 8'h00) begin
                wrec_cnt_q <= wrec_cnt_q - 8'h01;
            end
            pch_pulse_q <= pch_go;
            if (cmd_code == CMD_PRE) begin
                pch_pend_q <= 1'b1;
                pch_bank_q <= cmd_bank;
            end else if (rd_done && rd_ap_q) begin
                pch_pend_q <= 1'b1;
                pch_bank_q <= rd_bank_q;
            end else if (wr_last && wr_ap_q) begin
                pch_pend_q <= 1'b1;
                pch_bank_q <= wr_bank_q;
            end else if (pch_go) begin
                pch_pend_q <= 1'b0;
            end
        end
    end

    assign avs_readdata = avs_readdata_q;
    assign avs_waitrequest = wait_q;
    assign dq_o = dq_q;
    assign dq_oe = dq_oe_q;
    assign read_strobe_o = rs_q;
    assign read_strobe_oe = rs_oe_q;
    assign inversion_flag_pin_o = flag_q;
    assign inversion_flag_pin_oe = flag_oe_q;
    assign dq_odt_on = odt_q;
    assign precharge_pulse = pch_pulse_q;
    assign precharge_bank = pch_bank_q;
endmodule
`default_nettype wire

// ### verification/sgram_asserts.sv
// Concurrent checks on the read strobe, read data and termination pins.
`timescale 1ns/10ps
`default_nettype none
module sgram_asserts (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [31:0] dq_o,
    input wire logic dq_oe,
    input wire logic [3:0] read_strobe_o,
    input wire logic read_strobe_oe,
    input wire logic [3:0] inversion_flag_pin_o,
    input wire logic inversion_flag_pin_oe,
    input wire logic dq_odt_on
);
    // One clock domain, so clock and reset are named once.
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    oe_pair_a: assert property (dq_oe |-> read_strobe_oe)
        else $error("data driven without strobe");
    lane_same_a: assert property (
        read_strobe_oe |-> &read_strobe_o || !(|read_strobe_o))
        else $error("lane strobes differ");
    idle_still_a: assert property (
        !read_strobe_oe && !$past(read_strobe_oe) |-> $stable(read_strobe_o))
        else $error("strobe moved while released");
    pre_hi_lo_a: assert property ($rose(read_strobe_oe) |->
        read_strobe_o[0] ##1 !read_strobe_o[0] ##1 read_strobe_o[0] && dq_oe)
        else $error("bad read preamble");
    post_end_a: assert property ($fell(read_strobe_oe) |->
        $past(read_strobe_o[0]) && !$past(read_strobe_o[0], 2) && !dq_oe)
        else $error("bad read postamble");
    data_toggle_a: assert property (
        dq_oe && $past(dq_oe) |-> read_strobe_o[0] != $past(read_strobe_o[0]))
        else $error("strobe missed a data edge");
    dbi_flag_a: assert property (dq_oe && inversion_flag_pin_oe |->
        (inversion_flag_pin_o[0] ? $countones(dq_o[7:0]) < 4 :
            $countones(dq_o[7:0]) <= 4) &&
        (inversion_flag_pin_o[3] ? $countones(dq_o[31:24]) < 4 :
            $countones(dq_o[31:24]) <= 4))
        else $error("inversion flag wrong");
    odt_back_a: assert property ($fell(dq_odt_on) |-> ##[2:24] dq_odt_on)
        else $error("termination stayed off");
    // The bench should reach a preamble, an inverted lane and two chained bursts.
    pre_seen_c: cover property ($rose(read_strobe_oe));
    dbi_seen_c: cover property (inversion_flag_pin_oe && |inversion_flag_pin_o);
    chain_seen_c: cover property (dq_oe [*8] ##1 dq_oe);
endmodule
bind sgram_burst_data_path sgram_asserts sgram_asserts_i (.*);
`default_nettype wire

// ### verification/wr_ctrl_model.sv
// Controller-side model that sends one write burst on the write strobe.
`timescale 1ns/10ps
`default_nettype none
module wr_ctrl_model (
    input wire logic go,
    input wire logic [255:0] words,
    output logic write_strobe,
    output logic [31:0] dq,
    output logic [3:0] inv_flag
);
    // Strobe rests low outside frames; write inversion is never asked for.
    initial begin
        write_strobe = 1'b0;
        dq = 32'h0;
        inv_flag = 4'h0;
    end
    // The 13 ns offset keeps strobe edges off the core clock edges.
    always @(posedge go) begin
        #213;
        for (int i = 0; i < 8; i++) begin
            dq = words[i*32 +: 32];
            #100 write_strobe = !write_strobe;
            #100;
        end
        dq = ~dq;
        #100 write_strobe = 1'b1;
        #200 write_strobe = 1'b0;
    end
endmodule
`default_nettype wire

// ### verification/sgram_burst_data_path_bench.sv
// Self-checking bench: register access, write bursts and read bursts.
`timescale 1ns/10ps
`default_nettype none
module sgram_burst_data_path_bench;
    import sgram_burst_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0, rs_i, rs_o, fl_o;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q, dq_i, dq_o;
    logic [31:0] seed = 32'd92942;
    logic avs_waitrequest, dq_oe, rs_oe, fl_oe, odt, pch, ws, go = 1'b0;
    cmd_t cmd_code = CMD_NOP;
    logic [8:0] cmd_addr = 9'h0;
    logic [2:0] pbank;
    logic [5:0] col;
    logic [255:0] words;
    int bad_count = 0, n_compared = 0, n;
    sgram_burst_data_path sgram_burst_data_path_i (.core_clk(core_clk),
        .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmd_code(cmd_code),
        .cmd_bank(3'h0), .cmd_addr(cmd_addr), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe(dq_oe), .read_strobe_i(rs_i), .read_strobe_o(rs_o),
        .read_strobe_oe(rs_oe), .write_strobe_i(ws),
        .inversion_flag_pin_o(fl_o), .inversion_flag_pin_oe(fl_oe),
        .dq_odt_on(odt), .precharge_pulse(pch), .precharge_bank(pbank));
    wr_ctrl_model wr_ctrl_model_i (.go(go), .words(words),
        .write_strobe(ws), .dq(dq_i), .inv_flag(rs_i));
    // Free-running 20 MHz core clock.
    always #25 core_clk = !core_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected pins: flag enable, lane flags, then the data word.
    function automatic logic [36:0] dbi(input logic [31:0] w, input logic en);
        logic [36:0] r;
        r = {en, 4'h0, w};
        for (int l = 0; l < 4; l++)
            if (en && $countones(w[l*8 +: 8]) > 4) begin
                r[32+l] = 1'b1;
                r[l*8 +: 8] = ~w[l*8 +: 8];
            end
        return r;
    endfunction
    task automatic close_out();
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input string s, input logic [39:0] e, logic [39:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    // One bus cycle; the request stands until waitrequest is seen low.
    task automatic bus(input logic w, input logic [3:0] a, logic [31:0] d);
        int k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            bad_count++;
            close_out();
        end
        @(posedge core_clk);
    endtask
    task automatic cmd(input cmd_t c);
        cmd_code <= c;
        cmd_addr <= {6'h0, col[2:0]};
        @(posedge core_clk);
        cmd_code <= CMD_NOP;
        cmd_addr <= {6'h0, col[5:3]};
        @(posedge core_clk);
    endtask
    // Waits for the preamble, then checks every element on its cycle.
    task automatic grab(input int len, input logic en);
        int k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (rs_oe !== 1'b1 && k < 40);
        repeat (2) @(negedge core_clk);
        for (int i = 0; i < len; i++) begin
            cmp("read pins", dbi(words[(i%8)*32 +: 32], en),
                {fl_oe, fl_oe ? fl_o : 4'h0, dq_o});
            @(negedge core_clk);
        end
        repeat (3) @(negedge core_clk);
        cmp("bus released", 0, {dq_oe, rs_oe, k >= 40});
    endtask
    task automatic rd2(input int gap, input int len, input logic en);
        fork
            grab(len, en);
            begin
                cmd(CMD_READ);
                repeat (gap) @(posedge core_clk);
                cmd(CMD_READ);
                repeat (2) @(posedge core_clk);
                cmd(CMD_PRE);
                n = 0;
                while (pch !== 1'b1 && n < 40) begin
                    @(posedge core_clk);
                    n++;
                end
                cmp("precharge", 1, pch);
            end
        join
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        bus(0, REG_CONFIG, 0);
        cmp("config", CONFIG_RESET, q);
        bus(0, REG_TIMING, 0);
        cmp("timing", TIMING_RESET, q);
        bus(0, 4'hC, 0);
        cmp("unmapped", 0, q);
        cmd(CMD_ACT);
        for (int r = 0; r < 2; r++) begin
            col = xs();
            for (int i = 0; i < 8; i++) words[i*32 +: 32] = xs();
            if (r == 1) bus(1, REG_CONFIG, CONFIG_RESET | 32'h200);
            go <= 1'b1;
            cmd(CMD_WRITE);
            go <= 1'b0;
            // Busy shows up a few cycles after the command is taken.
            repeat (4) @(posedge core_clk);
            n = 0;
            do begin
                bus(0, REG_STATUS, 0);
                n++;
            end while (q[ST_WR_BUSY] !== 1'b0 && n < 80);
            cmp("write done", 0, q[ST_WR_BUSY]);
            // The second READ must wait until the first leaves its slot.
            rd2(5, 16, r[0]);
        end
        rd2(0, 8, 1'b1);
        bus(0, REG_STATUS, 0);
        cmp("read spacing", 1, q[ST_RD_ERR]);
        close_out();
    end
endmodule
`default_nettype wire
